// [verilog/coc_pkg.sv]
package coc_pkg;

    // ------------------------------------------------------------
    // Bus map
    // ------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
    localparam logic [7:0] OFS_CLK_STATUS = 8'h0c;
    localparam logic [7:0] OFS_MP_CTRL = 8'h10;
    localparam logic [7:0] OFS_SLOW_CTRL = 8'h14;

    // ------------------------------------------------------------
    // Control register fields (both oscillators share positions)
    // ------------------------------------------------------------
    localparam int CTRL_W = 16;
    localparam int BIT_LOCK = 12;
    localparam int STARTUP_LSB = 8;
    localparam int STARTUP_W = 3;
    localparam int BIT_REQ_GATE = 7;
    localparam int BIT_STBY_RUN = 6;
    localparam int BIT_AAMP = 5;
    localparam int BIT_OUT_GATE = 3;
    localparam int BIT_XTAL = 2;
    localparam int BIT_ENABLE = 1;
    localparam logic [15:0] SLOW_CTRL_RESET = 16'h0080;
    localparam logic [15:0] SLOW_CTRL_WMASK = 16'h17ee;
    localparam logic [15:0] MP_CTRL_RESET = 16'h0080;
    localparam logic [15:0] MP_CTRL_WMASK = 16'h00c6;

    // ------------------------------------------------------------
    // Status and interrupt bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 2;
    localparam int IRQ_READY_SET = 0;
    localparam int IRQ_READY_LOST = 1;
    localparam int CS_MP_RUN = 0;
    localparam int CS_SLOW_READY = 1;
    localparam int CS_SLOW_RUN = 2;

    // ------------------------------------------------------------
    // Start-up timing
    // ------------------------------------------------------------
    localparam int CNT_W = 18;
    localparam logic [1:0] SYNC_CYCLES = 2'h3;
    localparam int SYNC_STAGES = 3;
    localparam int N_PIN = 2;
    localparam int PIN_ULP = 0;
    localparam int PIN_SLOW = 1;

    typedef enum logic [3:0] {
        COC_IDLE = 4'h1,
        COC_COUNT = 4'h2,
        COC_SYNC = 4'h4,
        COC_READY = 4'h8
    } coc_state_t;

    // Start-up code to count of slow reference cycles
    function automatic logic [CNT_W-1:0] coc_startup_cycles(input logic [STARTUP_W-1:0] code);
        logic [CNT_W-1:0] n;
        n = 18'h00001;
        unique case (code)
            3'h0: n = 18'h00001;
            3'h1: n = 18'h00020;
            3'h2: n = 18'h00800;
            3'h3: n = 18'h01000;
            3'h4: n = 18'h04000;
            3'h5: n = 18'h08000;
            3'h6: n = 18'h10000;
            3'h7: n = 18'h20000;
        endcase
        return n;
    endfunction

endpackage

// [verilog/coc_startup_timer.sv]
`timescale 1ns/10ps
module coc_startup_timer (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic run,
    input wire logic ulp_tick,
    input wire logic osc_tick,
    input wire logic [coc_pkg::STARTUP_W-1:0] startup_code,
    output logic ready
);
    import coc_pkg::*;

    coc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] target;
    logic [1:0] sync_cnt;

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    // Count reference ticks, then oscillator edges, then flag ready
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= COC_IDLE;
            cnt <= '0;
            target <= '0;
            sync_cnt <= '0;
        end else if (clk_en) begin
            if (!run) begin
                state <= COC_IDLE;
                cnt <= '0;
                sync_cnt <= '0;
            end else begin
                unique case (state)
                    COC_IDLE: begin
                        target <= coc_startup_cycles(startup_code) - 18'h00001;
                        cnt <= '0;
                        state <= COC_COUNT;
                    end
                    COC_COUNT: begin
                        if (ulp_tick) begin
                            if (cnt == target) begin
                                state <= COC_SYNC;
                                sync_cnt <= '0;
                            end else begin
                                cnt <= cnt + 18'h00001;
                            end
                        end
                    end
                    COC_SYNC: begin
                        if (osc_tick) begin
                            if (sync_cnt == SYNC_CYCLES - 2'h1) begin
                                state <= COC_READY;
                            end else begin
                                sync_cnt <= sync_cnt + 2'h1;
                            end
                        end
                    end
                    COC_READY: begin
                        state <= COC_READY;
                    end
                endcase
            end
        end
    end

    assign ready = (state == COC_READY);

    // Count ends exactly on the selected reference tick
    count_end_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && run && state == COC_COUNT && ulp_tick && cnt == target) |=> (state == COC_SYNC))
        else $error("start-up count did not end at target");
    // Ready only follows the third oscillator edge
    ready_sync_a: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(ready) |-> ($past(state) == COC_SYNC && $past(sync_cnt) == 2'h2 && $past(osc_tick)))
        else $error("ready set without synchronization delay");

endmodule

// [verilog/coc_osc_ctrl.sv]
`timescale 1ns/10ps
module coc_osc_ctrl (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [coc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic standby_mode,
    input wire logic mp_clock_request,
    input wire logic slow_clock_request,
    input wire logic ulp_slow_clk_pin,
    input wire logic slow_crystal_in_pad,
    output logic mp_osc_run,
    output logic mp_crystal_select_pads,
    output logic mp_out_pad_gpio_free,
    output logic slow_osc_run,
    output logic slow_crystal_select_pads,
    output logic slow_out_pad_gpio_free,
    output logic slow_auto_amplitude_on,
    output logic slow_clock_output_on,
    output logic slow_crystal_ready_flag,
    output logic irq
);
    import coc_pkg::*;

    logic [CTRL_W-1:0] slow_ctrl;
    logic [CTRL_W-1:0] mp_ctrl;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic [N_PIN-1:0] pin_raw;
    logic [N_PIN-1:0] pin_tick;
    logic [31:0] rd_data;
    logic bus_access;
    logic bus_write;
    logic slow_lock;
    logic timer_ready;
    logic next_slow_run;
    logic next_mp_run;

    // Byte-lane write merge under a writable-bit mask
    function automatic logic [CTRL_W-1:0] merge_write(
        input logic [CTRL_W-1:0] old,
        input logic [31:0] data,
        input logic [3:0] sel,
        input logic [CTRL_W-1:0] wmask
    );
        logic [CTRL_W-1:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
        return (old & ~lane) | (data[CTRL_W-1:0] & lane);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pin_raw = {slow_crystal_in_pad, ulp_slow_clk_pin};

    generate
        for (genvar g = 0; g < N_PIN; g++) begin : g_sync
            logic [SYNC_STAGES-1:0] shift;
            logic level;
            logic tick;
            // Rising edge counts once second and third stages agree
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    shift <= '0;
                    level <= 1'b0;
                    tick <= 1'b0;
                end else if (clk_en) begin
                    shift <= {shift[SYNC_STAGES-2:0], pin_raw[g]};
                    if (shift[1] == shift[2]) begin
                        level <= shift[2];
                    end
                    tick <= (shift[1] == shift[2]) && shift[2] && !level;
                end
            end
            assign pin_tick[g] = tick;
        end
    endgenerate

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign bus_access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_write = bus_access && wb_we_i;
    assign slow_lock = slow_ctrl[BIT_LOCK];

    // One-cycle ack, dropped the cycle after
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (clk_en) begin
            wb_ack_o <= bus_access;
            if (bus_access && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // Read mux, unmapped reads return zero
    always_comb begin
        rd_data = '0;
        unique case (wb_adr_i)
            OFS_IRQ_STATUS: rd_data[IRQ_W-1:0] = irq_status;
            OFS_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask;
            OFS_CLK_STATUS: begin
                rd_data[CS_MP_RUN] = mp_osc_run;
                rd_data[CS_SLOW_READY] = slow_crystal_ready_flag;
                rd_data[CS_SLOW_RUN] = slow_osc_run;
            end
            OFS_MP_CTRL: rd_data[CTRL_W-1:0] = mp_ctrl;
            OFS_SLOW_CTRL: rd_data[CTRL_W-1:0] = slow_ctrl;
            default: rd_data = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Slow crystal control, frozen once locked
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            slow_ctrl <= SLOW_CTRL_RESET;
        end else if (clk_en) begin
            if (bus_write && wb_adr_i == OFS_SLOW_CTRL && !slow_lock) begin
                slow_ctrl <= merge_write(slow_ctrl, wb_dat_i, wb_sel_i, SLOW_CTRL_WMASK);
            end
        end
    end

    // Multipurpose oscillator control bits
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mp_ctrl <= MP_CTRL_RESET;
        end else if (clk_en) begin
            if (bus_write && wb_adr_i == OFS_MP_CTRL) begin
                mp_ctrl <= merge_write(mp_ctrl, wb_dat_i, wb_sel_i, MP_CTRL_WMASK);
            end
        end
    end

    // ------------------------------------------------------------
    // Oscillator run control
    // ------------------------------------------------------------
    always_comb begin
        next_slow_run = slow_ctrl[BIT_ENABLE]
            && (!slow_ctrl[BIT_REQ_GATE] || slow_clock_request)
            && (!standby_mode || slow_ctrl[BIT_STBY_RUN]);
        next_mp_run = mp_ctrl[BIT_ENABLE]
            && (!mp_ctrl[BIT_REQ_GATE] || mp_clock_request)
            && (!standby_mode || mp_ctrl[BIT_STBY_RUN]);
    end

    // Registered pad and oscillator controls
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            slow_osc_run <= 1'b0;
            mp_osc_run <= 1'b0;
            slow_crystal_select_pads <= 1'b0;
            slow_out_pad_gpio_free <= 1'b1;
            mp_crystal_select_pads <= 1'b0;
            mp_out_pad_gpio_free <= 1'b1;
            slow_auto_amplitude_on <= 1'b0;
            slow_clock_output_on <= 1'b0;
        end else if (clk_en) begin
            slow_osc_run <= next_slow_run;
            mp_osc_run <= next_mp_run;
            slow_crystal_select_pads <= slow_ctrl[BIT_XTAL];
            slow_out_pad_gpio_free <= !slow_ctrl[BIT_XTAL];
            mp_crystal_select_pads <= mp_ctrl[BIT_XTAL];
            mp_out_pad_gpio_free <= !mp_ctrl[BIT_XTAL];
            slow_auto_amplitude_on <= slow_ctrl[BIT_AAMP];
            slow_clock_output_on <= slow_ctrl[BIT_OUT_GATE];
        end
    end

    // ------------------------------------------------------------
    // Start-up and ready flag
    // ------------------------------------------------------------
    coc_startup_timer u_startup (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .run(slow_osc_run),
        .ulp_tick(pin_tick[PIN_ULP]),
        .osc_tick(pin_tick[PIN_SLOW]),
        .startup_code(slow_ctrl[STARTUP_LSB +: STARTUP_W]),
        .ready(timer_ready)
    );

    // Ready flag register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            slow_crystal_ready_flag <= 1'b0;
        end else if (clk_en) begin
            slow_crystal_ready_flag <= timer_ready;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_set[IRQ_READY_SET] = timer_ready && !slow_crystal_ready_flag;
    assign irq_set[IRQ_READY_LOST] = !timer_ready && slow_crystal_ready_flag;

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_status <= '0;
        end else if (clk_en) begin
            if (bus_write && wb_adr_i == OFS_IRQ_STATUS && wb_sel_i[0]) begin
                irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
        end
    end

    // Mask register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_mask <= '0;
        end else if (clk_en) begin
            if (bus_write && wb_adr_i == OFS_IRQ_MASK && wb_sel_i[0]) begin
                irq_mask <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // Level interrupt output
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    lock_freeze_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && slow_lock && bus_write && wb_adr_i == OFS_SLOW_CTRL) |=> $stable(slow_ctrl))
        else $error("locked register changed on write");
    lock_sticky_a: assert property (@(posedge clock) disable iff (sys_rst)
        slow_lock |=> slow_lock)
        else $error("lock released without reset");
    demand_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && slow_ctrl[BIT_REQ_GATE] && !slow_clock_request) |=> !slow_osc_run)
        else $error("slow osc runs without request");
    always_run_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && slow_ctrl[BIT_ENABLE] && !slow_ctrl[BIT_REQ_GATE] && !standby_mode) |=> slow_osc_run)
        else $error("enabled slow osc not running");
    standby_off_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && standby_mode && !slow_ctrl[BIT_STBY_RUN]) |=> !slow_osc_run)
        else $error("slow osc runs in standby");
    standby_run_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && standby_mode && slow_ctrl[BIT_STBY_RUN] && slow_ctrl[BIT_ENABLE]
            && !slow_ctrl[BIT_REQ_GATE]) |=> slow_osc_run)
        else $error("slow osc stopped in standby");
    disable_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !slow_ctrl[BIT_ENABLE]) |=> (!slow_osc_run ##2 !slow_crystal_ready_flag))
        else $error("disabled slow osc still running");
    mp_standby_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && standby_mode && mp_ctrl[BIT_STBY_RUN] && mp_ctrl[BIT_ENABLE]
            && (!mp_ctrl[BIT_REQ_GATE] || mp_clock_request)) |=> mp_osc_run)
        else $error("multipurpose osc stopped in standby");
    mp_enable_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !mp_ctrl[BIT_ENABLE]) |=> !mp_osc_run)
        else $error("disabled multipurpose osc running");
    mp_pads_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en |=> (mp_crystal_select_pads == $past(mp_ctrl[BIT_XTAL])
            && mp_out_pad_gpio_free != mp_crystal_select_pads))
        else $error("multipurpose pad select wrong");
    slow_pads_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en |=> (slow_crystal_select_pads == $past(slow_ctrl[BIT_XTAL])
            && slow_out_pad_gpio_free != slow_crystal_select_pads))
        else $error("slow pad select wrong");
    amp_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en |=> slow_auto_amplitude_on == $past(slow_ctrl[BIT_AAMP]))
        else $error("amplitude control mismatch");
    out_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        clk_en |=> slow_clock_output_on == $past(slow_ctrl[BIT_OUT_GATE]))
        else $error("slow clock output gate mismatch");

endmodule

// [dv/coc_xtal_model.sv]
`timescale 1ns/10ps
module coc_xtal_model #(
    parameter int XTAL_HALF = 4,
    parameter int ULP_HALF = 8
) (
    input wire logic clock,
    input wire logic osc_run,
    input wire logic hold_osc,
    output logic ulp_slow_clk_pin = 1'b0,
    output logic slow_crystal_in_pad = 1'b0
);
    int ulp_cnt = 0;
    int xtal_cnt = 0;

    // Free-running low-power reference clock
    always @(posedge clock) begin
        ulp_cnt <= (ulp_cnt == ULP_HALF-1) ? 0 : ulp_cnt + 1;
        if (ulp_cnt == ULP_HALF-1) ulp_slow_clk_pin <= ~ulp_slow_clk_pin;
    end

    // Crystal swings only while enabled; a held crystal is still stuck low
    always @(posedge clock) begin
        if (!osc_run || hold_osc) begin
            xtal_cnt <= 0;
            slow_crystal_in_pad <= 1'b0;
        end else begin
            xtal_cnt <= (xtal_cnt == XTAL_HALF-1) ? 0 : xtal_cnt + 1;
            if (xtal_cnt == XTAL_HALF-1) slow_crystal_in_pad <= ~slow_crystal_in_pad;
        end
    end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import coc_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, standby = 1'b0, mp_req = 1'b0, slow_req = 1'b0, hold = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, rdat;
    logic ack, mp_run, mp_sel, mp_free, s_run, s_sel, s_free, s_aamp, s_out, s_rdy, irq, ulp, xpad;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    always #5 clock = ~clock;

    coc_osc_ctrl dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .standby_mode(standby), .mp_clock_request(mp_req), .slow_clock_request(slow_req),
        .ulp_slow_clk_pin(ulp), .slow_crystal_in_pad(xpad), .mp_osc_run(mp_run),
        .mp_crystal_select_pads(mp_sel), .mp_out_pad_gpio_free(mp_free), .slow_osc_run(s_run),
        .slow_crystal_select_pads(s_sel), .slow_out_pad_gpio_free(s_free), .slow_auto_amplitude_on(s_aamp),
        .slow_clock_output_on(s_out), .slow_crystal_ready_flag(s_rdy), .irq(irq));

    coc_xtal_model model (.clock(clock), .osc_run(s_run), .hold_osc(hold), .ulp_slow_clk_pin(ulp),
        .slow_crystal_in_pad(xpad));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // ----------------------------------------
    // Bus and pin helpers
    // ----------------------------------------
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk(ack, 1'b1, "bus answer");
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp, msg);
    endtask

    task settle;
        repeat (6) @(posedge clock);
        #1;
    endtask

    task drive(input logic sb, input logic mr, input logic sr);
        @(posedge clock);
        standby <= sb;
        mp_req <= mr;
        slow_req <= sr;
        settle();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rd(OFS_SLOW_CTRL, 32'h0080, "slow ctrl reset");
        rd(OFS_MP_CTRL, 32'h0080, "mp ctrl reset");
        wb(1'b1, 8'hf0, 32'hffff_ffff);
        rd(8'hf0, 32'h0, "unmapped read");
        chk(s_free, 1'b1, "slow pad free at reset");
        chk(mp_free, 1'b1, "mp pad free at reset");
    endtask

    task t_mp;
        wb(1'b1, OFS_MP_CTRL, 32'h0046);
        settle();
        chk(mp_run, 1'b1, "mp enabled");
        chk({mp_sel, mp_free}, 2'b10, "mp crystal pads");
        drive(1'b1, 1'b0, 1'b0);
        chk(mp_run, 1'b1, "mp runs in standby");
        wb(1'b1, OFS_MP_CTRL, 32'h0006);
        settle();
        chk(mp_run, 1'b0, "mp stops in standby");
        wb(1'b1, OFS_MP_CTRL, 32'h00c2);
        settle();
        chk(mp_run, 1'b0, "mp standby no request");
        drive(1'b1, 1'b1, 1'b0);
        chk(mp_run, 1'b1, "mp standby request");
        wb(1'b1, OFS_MP_CTRL, 32'h0000);
        drive(1'b0, 1'b0, 1'b0);
        chk({mp_run, mp_sel, mp_free}, 3'b001, "mp disabled");
    endtask

    task t_slow;
        wb(1'b1, OFS_SLOW_CTRL, 32'h0082);
        settle();
        chk(s_run, 1'b0, "on demand idle");
        drive(1'b0, 1'b0, 1'b1);
        chk(s_run, 1'b1, "on demand request");
        wb(1'b1, OFS_SLOW_CTRL, 32'h0002);
        drive(1'b0, 1'b0, 1'b0);
        chk(s_run, 1'b1, "always on");
        drive(1'b1, 1'b0, 1'b0);
        chk(s_run, 1'b0, "standby stop");
        wb(1'b1, OFS_SLOW_CTRL, 32'h0042);
        settle();
        chk(s_run, 1'b1, "standby run");
        wb(1'b1, OFS_SLOW_CTRL, 32'h00c2);
        settle();
        chk(s_run, 1'b0, "standby on demand idle");
        drive(1'b1, 1'b0, 1'b1);
        chk(s_run, 1'b1, "standby on demand request");
        drive(1'b0, 1'b0, 1'b0);
        wb(1'b1, OFS_SLOW_CTRL, 32'h002e);
        settle();
        chk({s_aamp, s_out}, 2'b11, "amplitude and output on");
        chk({s_run, s_sel, s_free}, 3'b110, "slow crystal pads");
        wb(1'b1, OFS_SLOW_CTRL, 32'h0000);
        settle();
        chk({s_aamp, s_out}, 2'b00, "amplitude and output off");
        chk({s_run, s_sel, s_free}, 3'b001, "slow disabled");
    endtask

    // Start-up: reference ticks counted, crystal optionally held stuck
    task t_start(input logic [2:0] code, input int n, input int hc);
        int cnt;
        int t;
        logic ulp_q;
        wb(1'b1, OFS_SLOW_CTRL, 32'h0000);
        settle();
        hold <= (hc != 0);
        wb(1'b1, OFS_SLOW_CTRL, {21'h0, code, 8'h02});
        cnt = 0;
        t = 0;
        ulp_q = ulp;
        while (s_rdy !== 1'b1 && t < 3000) begin
            @(posedge clock);
            t++;
            if (ulp && !ulp_q) cnt++;
            ulp_q = ulp;
            if (t == hc) hold <= 1'b0;
        end
        chk(s_rdy, 1'b1, "ready reached");
        chk(t >= hc + 20, 1'b1, "ready waits for crystal");
        chk(cnt >= n - 1, 1'b1, "reference count too short");
        if (hc == 0) chk(cnt <= n + 4, 1'b1, "reference count too long");
    endtask

    task t_irq;
        wb(1'b1, OFS_SLOW_CTRL, 32'h0000);
        settle();
        wb(1'b1, OFS_IRQ_STATUS, 32'h3);
        wb(1'b1, OFS_IRQ_MASK, 32'h3);
        rd(OFS_IRQ_STATUS, 32'h0, "status cleared");
        t_start(3'h0, 1, 200);
        settle();
        chk(irq, 1'b1, "irq on ready");
        rd(OFS_IRQ_STATUS, 32'h1, "ready event");
        rd(OFS_CLK_STATUS, 32'h6, "clock status");
        wb(1'b1, OFS_IRQ_MASK, 32'h0);
        settle();
        chk(irq, 1'b0, "irq masked");
        wb(1'b1, OFS_IRQ_MASK, 32'h3);
        settle();
        chk(irq, 1'b1, "irq unmasked");
        wb(1'b1, OFS_IRQ_STATUS, 32'h1);
        settle();
        chk(irq, 1'b0, "irq cleared");
        wb(1'b1, OFS_SLOW_CTRL, 32'h0000);
        settle();
        chk(s_rdy, 1'b0, "ready lost");
        rd(OFS_IRQ_STATUS, 32'h2, "lost event");
        chk(irq, 1'b1, "irq on loss");
        wb(1'b1, OFS_IRQ_STATUS, 32'h2);
        settle();
        chk(irq, 1'b0, "irq cleared again");
    endtask

    // Clock enable low holds the run control still
    task t_freeze;
        wb(1'b1, OFS_SLOW_CTRL, 32'h0082);
        settle();
        @(posedge clock);
        clk_en <= 1'b0;
        slow_req <= 1'b1;
        settle();
        chk(s_run, 1'b0, "frozen by clock enable");
        @(posedge clock);
        clk_en <= 1'b1;
        settle();
        chk(s_run, 1'b1, "runs after unfreeze");
        drive(1'b0, 1'b0, 1'b0);
    endtask

    task t_lock;
        wb(1'b1, OFS_SLOW_CTRL, 32'hffff_ffff);
        rd(OFS_SLOW_CTRL, 32'h17ee, "lock write");
        wb(1'b1, OFS_SLOW_CTRL, 32'h0000);
        rd(OFS_SLOW_CTRL, 32'h17ee, "locked value");
        drive(1'b0, 1'b0, 1'b1);
        chk(s_run, 1'b1, "locked config active");
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        rd(OFS_SLOW_CTRL, 32'h0080, "lock freed by reset");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_mp();
        t_slow();
        t_start(3'h0, 1, 0);
        t_start(3'h1, 32, 0);
        t_irq();
        t_freeze();
        t_lock();
        summarize();
    end
endmodule
